//--- core/dpc_pkg.sv
// Shared constants for the display performance counter.
`default_nettype none
package dpc_pkg;
  localparam logic [19:0] ADDR_SRC_CFG   = 20'h73000;
  localparam logic [19:0] ADDR_STATUS    = 20'h73004;
  localparam logic [31:0] SRC_CFG_RESET  = 32'h00000000;
  localparam int          CFG_EN_BIT     = 31;
  localparam int          CFG_IRQ_BIT    = 30;
  localparam int          CFG_FRAME_BIT  = 29;
  localparam int          CFG_MIN_BIT    = 28;
  localparam int          CFG_SRC_HI     = 27;
  localparam int          CFG_SRC_LO     = 23;
  localparam logic [31:0] CFG_WRITE_MASK = 32'hFF80FFFF;
  localparam int          ST_OVF_BIT     = 31;
  localparam int          ST_FRAME_BIT   = 30;
  localparam int          ST_MIN_BIT     = 29;
  localparam int          ST_SRC_LO      = 24;
  localparam int          CNT_W          = 16;
  localparam int          SRC_W          = 5;
  localparam int          NUM_SRC        = 32;
  localparam logic [4:0]  SRC_OVL_REG    = 5'h00;
  localparam logic [4:0]  SRC_DDB_FIFO   = 5'h03;
endpackage
`default_nettype wire

//--- core/dpc_sync.sv
// Three-stage input synchroniser with second/third stage agreement.
`default_nettype none
module dpc_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_b,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;
  logic [W-1:0] out_nxt;

  // Output follows only bits where the second and third stages agree.
  always_comb begin
    out_nxt = (s2_r & s3_r) | (out_r & (s2_r ^ s3_r));
  end

  // Register chain; first stage feeds only the second.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_r  <= '0;
      s2_r  <= '0;
      s3_r  <= '0;
      out_r <= '0;
    end else if (i_ce) begin
      s1_r  <= i_async;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign o_sync = out_r;
endmodule
`default_nettype wire

//--- core/dpc_top.sv
// Display performance counter with source config and status registers.
//
// Behaviour
// - Counter runs only while config bit 31 is set; idle otherwise.
// - Config bit 30 enables the threshold match interrupt.
// - Bit 29 set clears per frame and sums; clear keeps the max or min over events.
// - New event value compared to stored; bit 28 picks max or min.
// - Bits 27:23 select the monitored source; code 0 is overlay register latency.
// - Counter changing to equal threshold bits 15:0 with interrupt enable raises interrupt.
// - Display buffer FIFO source uses threshold as level; never interrupts.
// - Status bit 31 flags 16-bit overflow; zero while count valid.
// - Status shows reset mode bit 30, max/min bit 29, source 28:24.
// - Status bits 15:0 return the current counter value.
// - Reserved bits are written as zero by software and read as zero.
// - Read-only status ignores writes and reflects hardware state only.
`default_nettype none
module dpc_top #(
  parameter int CNT_W = dpc_pkg::CNT_W,
  parameter int NSRC  = dpc_pkg::NUM_SRC
) (
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  input  wire logic              i_ce,
  input  wire logic [19:0]       i_addr,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  input  wire logic [31:0]       i_wdata,
  output logic      [31:0]       o_rdata,
  input  wire logic [NSRC-1:0]   i_evt_valid,
  input  wire logic [NSRC*CNT_W-1:0] i_evt_value,
  input  wire logic              i_frame_start,
  output logic                   o_irq,
  output logic      [CNT_W-1:0]  o_fifo_level
);

  ////////////////////////////////////////////////////////////////////////////
  // Frame marker crosses from the display timing pins.
  logic frame_s;
  logic frame_d_r;
  logic frame_d_nxt;
  logic frame_pulse;

  dpc_sync #(.W(1)) u_frame_sync (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .i_ce    (i_ce),
    .i_async (i_frame_start),
    .o_sync  (frame_s)
  );

  // The frame pin idles low and the delayed copy resets low, so reset leaves no false edge.
  assign frame_pulse = frame_s & ~frame_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register state.
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // True when a strobe is up and the address names the given register.
  function automatic logic reg_hit(input logic        strobe,
                                   input logic [19:0] addr,
                                   input logic [19:0] base);
    reg_hit = strobe && (addr == base);
  endfunction

  // Writes land only on the config register; reserved bits are dropped.
  // A write to the status address matches nothing here, so it is lost.
  always_comb begin
    cfg_nxt = cfg_r;
    if (reg_hit(i_wr, i_addr, dpc_pkg::ADDR_SRC_CFG)) begin
      cfg_nxt = i_wdata & dpc_pkg::CFG_WRITE_MASK;
    end
  end

  logic             en;
  logic             irq_en;
  logic             frame_mode;
  logic             min_mode;
  logic [4:0]       src_sel;
  logic [CNT_W-1:0] thresh;
  logic             is_ddb;

  assign en         = cfg_r[dpc_pkg::CFG_EN_BIT];
  assign irq_en     = cfg_r[dpc_pkg::CFG_IRQ_BIT];
  assign frame_mode = cfg_r[dpc_pkg::CFG_FRAME_BIT];
  assign min_mode   = cfg_r[dpc_pkg::CFG_MIN_BIT];
  assign src_sel    = cfg_r[dpc_pkg::CFG_SRC_HI:dpc_pkg::CFG_SRC_LO];
  assign thresh     = cfg_r[CNT_W-1:0];
  assign is_ddb     = (src_sel == dpc_pkg::SRC_DDB_FIFO);

  ////////////////////////////////////////////////////////////////////////////
  // Selected event source.
  logic             evt;
  logic [CNT_W-1:0] evt_val;

  // Mux the event strobe and value of the chosen source.
  always_comb begin
    evt     = i_evt_valid[src_sel];
    evt_val = i_evt_value[src_sel*CNT_W +: CNT_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, overflow and match state.
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             ovf_r;
  logic             ovf_nxt;
  logic             have_r;
  logic             have_nxt;
  logic             irq_r;
  logic             irq_nxt;

  // Returns the value to keep, by max or min selection.
  function automatic logic [CNT_W-1:0] pick(input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b,
                                            input logic             want_min);
    if (want_min) begin
      pick = (a < b) ? a : b;
    end else begin
      pick = (a > b) ? a : b;
    end
  endfunction

  // Counter update: per-frame sum or per-event max/min with overflow hold.
  always_comb begin
    logic [CNT_W:0] sum;
    sum      = {1'b0, cnt_r} + {1'b0, evt_val};
    cnt_nxt  = cnt_r;
    ovf_nxt  = ovf_r;
    have_nxt = have_r;
    irq_nxt  = 1'b0;
    frame_d_nxt = frame_s; // Delayed copy for the frame edge detector.
    if (!en) begin
      cnt_nxt  = '0;
      ovf_nxt  = 1'b0;
      have_nxt = 1'b0;
    end else if (frame_mode) begin
      if (frame_pulse) begin
        // An event in the frame-start cycle opens the new frame's sum, so it is not lost.
        cnt_nxt = evt ? evt_val : '0;
        ovf_nxt = 1'b0;
      end else if (evt && !ovf_r) begin
        if (sum[CNT_W]) begin
          ovf_nxt = 1'b1;
        end else begin
          cnt_nxt = sum[CNT_W-1:0];
        end
      end
    end else if (evt) begin
      // Per-event: first event loads the counter, later ones kept by compare.
      if (!have_r) begin
        cnt_nxt = evt_val;
      end else begin
        cnt_nxt = pick(cnt_r, evt_val, min_mode);
      end
      have_nxt = 1'b1;
      ovf_nxt  = 1'b0;
    end
    // Matching only on a change keeps the interrupt a single pulse while the count rests.
    if (en && irq_en && !is_ddb && cnt_nxt == thresh && cnt_nxt != cnt_r) begin
      irq_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read data; status built from hardware state only.
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (reg_hit(i_rd, i_addr, dpc_pkg::ADDR_SRC_CFG)) begin
      rdata_nxt = cfg_r;
    end else if (reg_hit(i_rd, i_addr, dpc_pkg::ADDR_STATUS)) begin
      rdata_nxt[dpc_pkg::ST_OVF_BIT]   = ovf_r;
      rdata_nxt[dpc_pkg::ST_FRAME_BIT] = frame_mode;
      rdata_nxt[dpc_pkg::ST_MIN_BIT]   = min_mode;
      rdata_nxt[dpc_pkg::ST_SRC_LO +: dpc_pkg::SRC_W] = src_sel;
      rdata_nxt[CNT_W-1:0]             = cnt_r;
    end
  end

  // Configuration register; clock enable freezes it.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r <= dpc_pkg::SRC_CFG_RESET;
    end else if (i_ce) begin
      cfg_r <= cfg_nxt;
    end
  end

  // Counter group registers; clock enable freezes them.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_r     <= '0;
      ovf_r     <= 1'b0;
      have_r    <= 1'b0;
      irq_r     <= 1'b0;
      frame_d_r <= 1'b0;
    end else if (i_ce) begin
      cnt_r     <= cnt_nxt;
      ovf_r     <= ovf_nxt;
      have_r    <= have_nxt;
      irq_r     <= irq_nxt;
      frame_d_r <= frame_d_nxt;
    end
  end

  // Read data register; it loads zero in every enabled cycle without a read.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= 32'h00000000;
    end else if (i_ce) begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data and interrupt come from flip-flops; the level echo follows the config.
  // Users must note the level output reads zero unless the buffer FIFO source is chosen.
  assign o_rdata      = rdata_r;
  assign o_irq        = irq_r;
  assign o_fifo_level = is_ddb ? thresh : '0;

endmodule
`default_nettype wire

//--- verification/dpc_asserts.sv
// Port checker for the display performance counter.
`default_nettype none
module dpc_asserts #(
  parameter int CNT_W = 16,
  parameter int NSRC  = 32
) (
  input wire logic             i_clk,
  input wire logic             i_rst_b,
  input wire logic             i_ce,
  input wire logic [19:0]      i_addr,
  input wire logic             i_wr,
  input wire logic             i_rd,
  input wire logic [31:0]      i_wdata,
  input wire logic [31:0]      o_rdata,
  input wire logic [NSRC-1:0]  i_evt_valid,
  input wire logic             o_irq,
  input wire logic [CNT_W-1:0] o_fifo_level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic        rd_cfg;
  logic        rd_st;
  ////////////////////////////////////////////////////////////
  // Shadow of the config register, built from accepted writes.
  always_comb begin
    cfg_nxt = cfg_r;
    if (i_ce && i_wr && i_addr == dpc_pkg::ADDR_SRC_CFG) begin
      cfg_nxt = i_wdata & dpc_pkg::CFG_WRITE_MASK;
    end
  end
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_r <= 32'h00000000;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end
  // Accepted reads of each register.
  assign rd_cfg = i_ce && i_rd && i_addr == dpc_pkg::ADDR_SRC_CFG;
  assign rd_st  = i_ce && i_rd && i_addr == dpc_pkg::ADDR_STATUS;
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  AST_CFG_READ: assert property ($past(rd_cfg) |-> o_rdata == $past(cfg_r))
    else $error("config readback differs");
  AST_STAT_CFG: assert property ($past(rd_st) |-> o_rdata[30:24] == $past(cfg_r[29:23]))
    else $error("status mode fields differ");
  AST_STAT_RSV: assert property ($past(rd_st) |-> o_rdata[23:16] == 8'h00)
    else $error("status reserved bits set");
  AST_IRQ_EN: assert property (o_irq |-> $past(cfg_r[31] && cfg_r[30]))
    else $error("irq while not enabled");
  AST_IRQ_FIFO: assert property (o_irq |-> $past(cfg_r[27:23]) != dpc_pkg::SRC_DDB_FIFO)
    else $error("irq on fifo source");
  AST_FIFO_LVL: assert property ($stable(cfg_r) |->
    o_fifo_level == (cfg_r[27:23] == dpc_pkg::SRC_DDB_FIFO ? cfg_r[CNT_W-1:0] : '0))
    else $error("fifo level wrong");
  AST_IRQ_PULSE: assert property (o_irq && i_ce |=> !o_irq)
    else $error("irq longer than one cycle");
  AST_IRQ_CAUSE: assert property (o_irq |-> $past(|i_evt_valid) || $past(cfg_r[15:0]) == 16'h0000)
    else $error("irq without event");
endmodule
bind dpc_top dpc_asserts #(.CNT_W(CNT_W), .NSRC(NSRC)) u_asserts (.i_clk, .i_rst_b, .i_ce, .i_addr,
  .i_wr, .i_rd, .i_wdata, .o_rdata, .i_evt_valid, .o_irq, .o_fifo_level);
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the display performance counter.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [19:0] CFG_A = dpc_pkg::ADDR_SRC_CFG;
  localparam logic [19:0] ST_A  = dpc_pkg::ADDR_STATUS;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_frame_start = 1'b0;
  logic pend = 1'b0, o_irq;
  logic [19:0]  i_addr = '0;
  logic [31:0]  i_wdata = '0, i_evt_valid = '0, cfg = '0, rnd = 32'h4DF4, irq_n = '0, o_rdata;
  logic [511:0] i_evt_value = '0;
  logic [15:0]  o_fifo_level;
  logic [31:0]  exp_q[$], msk_q[$];
  logic [31:0]  exp_w, msk_w;
  int           bad_count = 0, cmp_count = 0;
  always #25 i_clk = ~i_clk;
  dpc_top uut (.i_clk, .i_rst_b, .i_ce, .i_addr, .i_wr, .i_rd, .i_wdata, .o_rdata, .i_evt_valid,
    .i_evt_value, .i_frame_start, .o_irq, .o_fifo_level);
  ////////////////////////////////////////////////////////////
  // Compare one result and keep the tallies.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Xorshift source of random values.
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  // Expected status word for the current config.
  function automatic logic [31:0] st(input logic ovf, input logic [15:0] cnt);
    return {ovf, cfg[29:23], 8'h00, cnt};
  endfunction
  // One register access; a read notes its expected value and mask.
  task automatic acc(input logic w, input logic [19:0] a, input logic [31:0] d, input logic [31:0] m);
    @(negedge i_clk);
    i_wr = w;
    i_rd = !w;
    i_addr = a;
    i_wdata = d;
    if (!w) exp_q.push_back(d);
    if (!w) msk_q.push_back(m);
    if (w && a == CFG_A) cfg = d & dpc_pkg::CFG_WRITE_MASK;
    @(negedge i_clk);
    i_wr = 1'b0;
    i_rd = 1'b0;
  endtask
  // One-cycle event on a source; the value changes once released.
  task automatic ev(input int s, input logic [15:0] v);
    @(negedge i_clk);
    i_evt_valid[s] = 1'b1;
    i_evt_value[s*16 +: 16] = v;
    @(negedge i_clk);
    i_evt_valid = '0;
    i_evt_value[s*16 +: 16] = ~v;
  endtask
  // Frame marker with room for the synchroniser delay.
  task automatic fr();
    @(negedge i_clk);
    i_frame_start = 1'b1;
    repeat (6) @(negedge i_clk);
    i_frame_start = 1'b0;
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Read data is compared with the oldest note one cycle after the read edge.
  always @(posedge i_clk) pend <= i_rd;
  always @(negedge i_clk) begin
    if (pend) begin
      msk_w = msk_q.pop_front();
      exp_w = exp_q.pop_front();
      chk(o_rdata & msk_w, exp_w & msk_w);
    end
  end
  // Interrupt pulses are counted.
  always @(posedge i_clk) begin
    if (o_irq === 1'b1) irq_n <= irq_n + 32'h1;
  end
  // Watchdog cuts a hang short.
  initial begin
    #50us;
    bad_count++;
    wrap_up();
  end
  // Main sequence.
  initial begin
    repeat (2) @(negedge i_clk);
    i_rst_b = 1'b1;
    acc(1'b0, CFG_A, '0, '1);
    acc(1'b0, ST_A, '0, '1);
    acc(1'b1, CFG_A, xs() & 32'h7F80FFFF, '1);
    acc(1'b0, CFG_A, cfg, '1);
    acc(1'b1, ST_A, '1, '1);
    acc(1'b0, ST_A, st(1'b0, 16'h0000), '1);
    ev(5, 16'h0900);
    acc(1'b1, CFG_A, 32'hC280001E, '1);
    ev(5, 16'h0007);
    acc(1'b0, ST_A, st(1'b0, 16'h0007), '1);
    ev(6, 16'h03E7);
    ev(5, 16'h001E);
    ev(5, 16'h0014);
    acc(1'b0, ST_A, st(1'b0, 16'h001E), '1);
    chk(irq_n, 32'h1);
    @(negedge i_clk);
    i_ce = 1'b0;
    ev(5, 16'h0050);
    i_ce = 1'b1;
    acc(1'b0, ST_A, st(1'b0, 16'h001E), '1);
    acc(1'b1, CFG_A, 32'h9280000C, '1);
    ev(5, 16'h001C);
    ev(5, 16'h000C);
    ev(5, 16'h0019);
    acc(1'b0, ST_A, st(1'b0, 16'h000C), '1);
    chk(irq_n, 32'h1);
    acc(1'b1, CFG_A, 32'hC1800028, '1);
    @(negedge i_clk);
    chk({16'h0000, o_fifo_level}, 32'h28);
    ev(3, 16'h0028);
    repeat (2) @(negedge i_clk);
    chk(irq_n, 32'h1);
    acc(1'b1, CFG_A, 32'hE2800064, '1);
    fr();
    ev(5, 16'h003C);
    ev(5, 16'h0028);
    acc(1'b0, ST_A, st(1'b0, 16'h0064), '1);
    chk(irq_n, 32'h2);
    ev(5, 16'hFFF0);
    acc(1'b0, ST_A, st(1'b1, 16'h0064), '1);
    fr();
    acc(1'b0, ST_A, st(1'b0, 16'h0000), '1);
    repeat (2) @(negedge i_clk);
    if (exp_q.size() != 0) bad_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
